// file: verilog/stm_pkg.sv
package stm_pkg;
	// ---------------------------------------------------------------
	// status word layout
	// ---------------------------------------------------------------
	localparam int unsigned SW_W       = 32;
	localparam int unsigned BIT_N      = 31;
	localparam int unsigned BIT_C      = 29;
	localparam int unsigned BIT_V      = 28;
	localparam int unsigned FLAG_LSB   = 28;
	localparam int unsigned CC_W       = 4;
	localparam int unsigned MODE_W     = 5;
	localparam logic [31:0] SW_DEFINED = 32'hf00000ff;
	localparam logic [31:0] SW_FLAGS   = 32'hf0000000;
	localparam logic [31:0] SW_RESET   = 32'h000000d3;
	localparam logic [4:0]  MODE_USER  = 5'h10;
	localparam logic [4:0]  MODE_FAST  = 5'h11;
	localparam logic [4:0]  MODE_IRQ   = 5'h12;
	localparam logic [4:0]  MODE_SVC   = 5'h13;
	localparam logic [4:0]  MODE_ABT   = 5'h17;
	localparam logic [4:0]  MODE_UND   = 5'h1b;
	localparam int unsigned BANK_N     = 5;
	localparam int unsigned BANK_IW    = 3;
	localparam logic [2:0]  BANK_FAST  = 3'h0;
	localparam logic [2:0]  BANK_IRQ   = 3'h1;
	localparam logic [2:0]  BANK_SVC   = 3'h2;
	localparam logic [2:0]  BANK_ABT   = 3'h3;
	localparam logic [2:0]  BANK_UND   = 3'h4;
	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------
	localparam logic [31:0] SRD_MASK   = 32'h0fbf0fff;
	localparam logic [31:0] SRD_PAT    = 32'h010f0000;
	localparam logic [31:0] SWR_MASK   = 32'h0fbffff0;
	localparam logic [31:0] SWR_PAT    = 32'h0129f000;
	localparam logic [31:0] SWF_MASK   = 32'h0dbff000;
	localparam logic [31:0] SWF_PAT    = 32'h0128f000;
	localparam logic [31:0] MUL_MASK   = 32'h0fc000f0;
	localparam logic [31:0] MUL_PAT    = 32'h00000090;
	localparam int unsigned IR_COND_LO = 28;
	localparam int unsigned IR_IMM     = 25;
	localparam int unsigned IR_SAVED   = 22;
	localparam int unsigned IR_ACC     = 21;
	localparam int unsigned IR_SETF    = 20;
	localparam int unsigned MUL_RD_LO  = 16;
	localparam int unsigned RD_LO      = 12;
	localparam int unsigned RIDX_W     = 4;
	localparam int unsigned ROT_LSB    = 8;
	localparam int unsigned ROT_W      = 4;
	localparam int unsigned IMM_W      = 8;
	localparam logic [2:0]  CCG_EQ     = 3'h0;
	localparam logic [2:0]  CCG_CS     = 3'h1;
	localparam logic [2:0]  CCG_MI     = 3'h2;
	localparam logic [2:0]  CCG_VS     = 3'h3;
	localparam logic [2:0]  CCG_HI     = 3'h4;
	localparam logic [2:0]  CCG_GE     = 3'h5;
	localparam logic [2:0]  CCG_GT     = 3'h6;
	localparam logic [2:0]  CCG_AL     = 3'h7;
	// ---------------------------------------------------------------
	// multiplier and register bus
	// ---------------------------------------------------------------
	localparam int unsigned BOOTH_W    = 8;
	localparam logic [2:0]  MSTEP_MAX  = 3'h4;
	localparam int unsigned REG_AW     = 8;
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_SAVED  = 8'h08;
	localparam logic [7:0]  REG_LASTCY = 8'h0c;
	localparam logic [7:0]  REG_RETIRE = 8'h10;
	localparam int unsigned CTRL_EN    = 0;
	localparam int unsigned HTRANS_ACT = 1;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic        HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MUL  = 2'h1,
		ST_ACC  = 2'h3
	} stm_state_t;

	typedef struct packed {
		logic [31:0] rm;
		logic [31:0] rs;
		logic [31:0] rn;
	} stm_opnd_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  idx;
		logic [31:0] data;
	} stm_wb_t;

	function automatic logic stm_cond_pass(input logic [3:0] cc, input logic [3:0] f);
		logic r;
		r = 1'b0;
		unique case (cc[3:1])
			CCG_EQ: r = f[2];
			CCG_CS: r = f[1];
			CCG_MI: r = f[3];
			CCG_VS: r = f[0];
			CCG_HI: r = f[1] & ~f[2];
			CCG_GE: r = (f[3] == f[0]);
			CCG_GT: r = (f[3] == f[0]) & ~f[2];
			CCG_AL: r = 1'b1;
		endcase
		return r ^ cc[0];
	endfunction

	// booth groups needed: fewest whose upper remainder is pure sign extension
	function automatic logic [2:0] stm_mul_steps(input logic [31:0] b);
		logic [2:0]         m;
		logic signed [31:0] s;
		m = MSTEP_MAX;
		for (int k = int'(MSTEP_MAX) - 1; k >= 1; k--) begin
			s = $signed(b) >>> (BOOTH_W * k);
			if (s == '0 || s == '1) begin
				m = 3'(k);
			end
		end
		return m;
	endfunction

	function automatic logic [BANK_IW:0] stm_bank_of(input logic [MODE_W-1:0] mode);
		logic [BANK_IW:0] r;
		r = '0;
		unique case (mode)
			MODE_FAST: r = {1'b1, BANK_FAST};
			MODE_IRQ:  r = {1'b1, BANK_IRQ};
			MODE_SVC:  r = {1'b1, BANK_SVC};
			MODE_ABT:  r = {1'b1, BANK_ABT};
			MODE_UND:  r = {1'b1, BANK_UND};
			default:   r = '0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] stm_rotr(input logic [IMM_W-1:0] imm,
		input logic [ROT_W-1:0] rot);
		logic [63:0] dbl;
		logic [4:0]  amt;
		amt = {rot, 1'b0};
		dbl = {2{32'(imm)}};
		return dbl[amt +: 32];
	endfunction
endpackage

// file: verilog/stm_booth.sv
module stm_booth #(
	parameter int unsigned W    = stm_pkg::SW_W,
	parameter int unsigned STEP = stm_pkg::BOOTH_W
)(
	input  logic         i_clk,
	input  logic         i_reset_n,
	input  logic         i_start,
	input  logic [W-1:0] i_mcand,
	input  logic [W-1:0] i_mplier,
	output logic         o_done,
	output logic [W-1:0] o_product
);
	import stm_pkg::*;

	localparam int unsigned DW = STEP + 2;

	logic [W-1:0] acc_reg;
	logic [W-1:0] mcand_reg;
	logic [W-1:0] mplier_reg;
	logic         prev_reg;
	logic         sign_reg;
	logic [2:0]   left_reg;
	logic         done_reg;

	// one radix-2^STEP booth digit times the shifted multiplicand, low bits only;
	// the last group borrows the operand's sign so an early stop needs no fix-up cycle
	function automatic logic [W-1:0] booth_term(input logic [W-1:0] a,
		input logic [STEP-1:0] grp, input logic top, input logic prev);
		logic signed [DW-1:0]   digit;
		logic signed [W+DW-1:0] prod;
		digit = DW'($signed({top, grp})) + $signed({{(DW-1){1'b0}}, prev});
		prod  = $signed({1'b0, a}) * digit;
		return prod[W-1:0];
	endfunction

	wire logic [2:0]   m_steps  = stm_mul_steps(i_mplier);
	wire logic         stepping = (left_reg != '0);
	wire logic         last_go  = (m_steps == 3'h1);
	wire logic         last_run = (left_reg == 3'h1);
	wire logic         top_go   = last_go ? i_mplier[W-1] : i_mplier[STEP-1];
	wire logic         top_run  = last_run ? sign_reg : mplier_reg[STEP-1];
	wire logic [W-1:0] term_go  = booth_term(i_mcand, i_mplier[STEP-1:0], top_go, 1'b0);
	wire logic [W-1:0] term_run = booth_term(mcand_reg, mplier_reg[STEP-1:0], top_run,
		prev_reg);

	// ---------------------------------------------------------------
	// array cycles: first group at start, then one group per clock
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_reg    <= '0;
			mcand_reg  <= '0;
			mplier_reg <= '0;
			prev_reg   <= 1'b0;
			sign_reg   <= 1'b0;
			left_reg   <= '0;
			done_reg   <= 1'b0;
		end else if (i_start) begin
			acc_reg    <= term_go;
			mcand_reg  <= i_mcand << STEP;
			mplier_reg <= i_mplier >> STEP;
			prev_reg   <= i_mplier[STEP-1];
			sign_reg   <= i_mplier[W-1];
			left_reg   <= m_steps - 3'h1;
			done_reg   <= (m_steps == 3'h1);
		end else if (stepping) begin
			acc_reg    <= acc_reg + term_run;
			mcand_reg  <= mcand_reg << STEP;
			mplier_reg <= mplier_reg >> STEP;
			prev_reg   <= mplier_reg[STEP-1];
			left_reg   <= left_reg - 3'h1;
			done_reg   <= (left_reg == 3'h1);
		end else begin
			done_reg   <= 1'b0;
		end
	end

	assign o_done    = done_reg;
	assign o_product = acc_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_booth_full;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_start && m_steps == MSTEP_MAX |=> !o_done [*3] ##1 o_done;
	endproperty
	a_booth_full: assert property (p_booth_full) else $error("four group multiply length");

	property p_booth_short;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_start && m_steps == 3'h1 |=> o_done && o_product == $past(i_mcand * i_mplier);
	endproperty
	a_booth_short: assert property (p_booth_short) else $error("one group multiply wrong");
endmodule

// file: verilog/stm_core.sv
module stm_core (
	input  logic               i_clk,
	input  logic               i_reset_n,
	input  logic               i_issue_valid,
	output logic               o_issue_ready,
	input  logic [31:0]        i_instr,
	input  stm_pkg::stm_opnd_t i_opnd,
	output stm_pkg::stm_wb_t   o_wb,
	output logic               o_retire,
	output logic [31:0]        o_status,
	input  logic               i_hsel,
	input  logic [31:0]        i_haddr,
	input  logic [1:0]         i_htrans,
	input  logic               i_hwrite,
	input  logic [2:0]         i_hsize,
	input  logic [31:0]        i_hwdata,
	input  logic               i_hready,
	output logic               o_hreadyout,
	output logic [31:0]        o_hrdata,
	output logic               o_hresp
);
	import stm_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	stm_state_t         state_reg;
	stm_state_t         state_next;
	logic [31:0]        cur_reg;
	logic [31:0]        cur_next;
	logic [31:0]        saved_reg [BANK_N];
	stm_wb_t            wb_reg;
	stm_wb_t            wb_next;
	logic               retire_reg;
	logic               retire_next;
	logic [3:0]         dest_reg;
	logic [31:0]        rn_reg;
	logic [31:0]        prod_reg;
	logic [31:0]        mcand_reg;
	logic [31:0]        mplier_reg;
	logic               acc_reg;
	logic               setf_reg;
	logic [2:0]         msteps_reg;
	logic [7:0]         run_reg;
	logic [7:0]         lastcy_reg;
	logic [31:0]        retired_reg;
	logic               ctrl_en_reg;
	logic               wr_pend_reg;
	logic [REG_AW-1:0]  wr_addr_reg;
	logic [31:0]        hrdata_reg;
	logic               booth_done;
	logic [31:0]        booth_prod;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire logic          issue     = i_issue_valid & o_issue_ready;
	wire logic          cond_ok   = stm_cond_pass(i_instr[IR_COND_LO +: CC_W],
		cur_reg[FLAG_LSB +: CC_W]);
	wire logic          go        = issue & cond_ok;
	wire logic          dec_read  = (i_instr & SRD_MASK) == SRD_PAT;
	wire logic          dec_wfull = (i_instr & SWR_MASK) == SWR_PAT;
	wire logic          dec_wflag = (i_instr & SWF_MASK) == SWF_PAT;
	wire logic          dec_mul   = (i_instr & MUL_MASK) == MUL_PAT;
	wire logic          use_saved = i_instr[IR_SAVED];
	wire logic [BANK_IW:0] bank   = stm_bank_of(cur_reg[MODE_W-1:0]);
	wire logic          bank_ok   = bank[BANK_IW];
	wire logic [2:0]    bank_idx  = bank[BANK_IW-1:0];
	wire logic          is_user   = cur_reg[MODE_W-1:0] == MODE_USER;
	wire logic [31:0]   imm_val   = stm_rotr(i_instr[IMM_W-1:0], i_instr[ROT_LSB +: ROT_W]);
	wire logic [31:0]   src_val   = (dec_wflag & i_instr[IR_IMM]) ? imm_val : i_opnd.rm;

	// ---------------------------------------------------------------
	// status transfers
	// ---------------------------------------------------------------
	// saved access outside a banked mode: write dropped, read gives zero
	wire logic          wr_any    = go & (dec_wfull | dec_wflag);
	wire logic          wr_cur    = wr_any & ~use_saved;
	wire logic          wr_saved  = wr_any & use_saved & bank_ok;
	wire logic [31:0]   cur_mask  = (dec_wflag | is_user) ? SW_FLAGS : SW_DEFINED;
	wire logic [31:0]   sav_mask  = dec_wflag ? SW_FLAGS : SW_DEFINED;
	wire logic [31:0]   sav_now   = bank_ok ? saved_reg[bank_idx] : '0;
	wire logic [31:0]   rd_val    = use_saved ? sav_now : cur_reg;
	wire logic [31:0]   cur_wval  = (cur_reg & ~cur_mask) | (src_val & cur_mask);
	wire logic [31:0]   sav_wval  = (sav_now & ~sav_mask) | (src_val & sav_mask);

	// ---------------------------------------------------------------
	// multiply sequence
	// ---------------------------------------------------------------
	wire logic          mul_start = go & dec_mul;
	wire logic          in_acc    = state_reg == ST_ACC;
	wire logic          mul_fin   = (state_reg == ST_MUL & booth_done & ~acc_reg) | in_acc;
	wire logic [31:0]   mul_res   = in_acc ? prod_reg + rn_reg : booth_prod;

	// carry is left as it was; overflow must be
	assign cur_next = (mul_fin & setf_reg) ?
		{mul_res[BIT_N], ~|mul_res, cur_reg[BIT_C:0]} :
		(wr_cur ? cur_wval : cur_reg);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (mul_start) begin
				state_next = ST_MUL;
			end
			ST_MUL: if (booth_done) begin
				state_next = acc_reg ? ST_ACC : ST_IDLE;
			end
			ST_ACC: state_next = ST_IDLE;
		endcase
	end

	assign wb_next = '{
		valid: (go & dec_read) | mul_fin,
		idx:   mul_fin ? dest_reg : i_instr[RD_LO +: RIDX_W],
		data:  mul_fin ? mul_res : rd_val
	};
	assign retire_next = (issue & ~mul_start) | mul_fin;

	stm_booth #(
		.W    (SW_W),
		.STEP (BOOTH_W)
	) u_booth (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_start   (mul_start),
		.i_mcand   (i_opnd.rm),
		.i_mplier  (i_opnd.rs),
		.o_done    (booth_done),
		.o_product (booth_prod)
	);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg  <= ST_IDLE;
			cur_reg    <= SW_RESET;
			wb_reg     <= '0;
			retire_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			cur_reg    <= cur_next;
			wb_reg     <= wb_next;
			retire_reg <= retire_next;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < BANK_N; i++) begin
				saved_reg[i] <= '0;
			end
		end else if (wr_saved) begin
			saved_reg[bank_idx] <= sav_wval;
		end
	end

	// operands are latched at issue so the register file may move on
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dest_reg   <= '0;
			rn_reg     <= '0;
			mcand_reg  <= '0;
			mplier_reg <= '0;
			acc_reg    <= 1'b0;
			setf_reg   <= 1'b0;
			msteps_reg <= '0;
		end else if (mul_start) begin
			dest_reg   <= i_instr[MUL_RD_LO +: RIDX_W];
			rn_reg     <= i_opnd.rn;
			mcand_reg  <= i_opnd.rm;
			mplier_reg <= i_opnd.rs;
			acc_reg    <= i_instr[IR_ACC];
			setf_reg   <= i_instr[IR_SETF];
			msteps_reg <= stm_mul_steps(i_opnd.rs);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prod_reg <= '0;
		end else if (state_reg == ST_MUL && booth_done) begin
			prod_reg <= booth_prod;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_reg     <= '0;
			lastcy_reg  <= '0;
			retired_reg <= '0;
		end else begin
			run_reg     <= issue ? 8'h1 : run_reg + 8'(state_reg != ST_IDLE);
			lastcy_reg  <= retire_next ? (issue ? 8'h1 : run_reg + 8'h1) : lastcy_reg;
			retired_reg <= retired_reg + 32'(retire_next);
		end
	end

	// ---------------------------------------------------------------
	// register bus slave
	// ---------------------------------------------------------------
	// zero wait states; only the low address byte is decoded
	wire logic              ahb_go  = i_hsel & i_htrans[HTRANS_ACT] & i_hready;
	wire logic [REG_AW-1:0] ahb_off = i_haddr[REG_AW-1:0];
	wire logic [31:0]       reg_rd  =
		(ahb_off == REG_CTRL)   ? 32'(ctrl_en_reg) :
		(ahb_off == REG_STATUS) ? cur_reg :
		(ahb_off == REG_SAVED)  ? sav_now :
		(ahb_off == REG_LASTCY) ? 32'(lastcy_reg) :
		(ahb_off == REG_RETIRE) ? retired_reg : '0;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			hrdata_reg  <= '0;
			ctrl_en_reg <= 1'b1;
		end else begin
			wr_pend_reg <= ahb_go & i_hwrite & (i_hsize == HSIZE_WORD);
			wr_addr_reg <= ahb_go ? ahb_off : wr_addr_reg;
			hrdata_reg  <= (ahb_go & ~i_hwrite) ? reg_rd : hrdata_reg;
			if (wr_pend_reg && wr_addr_reg == REG_CTRL) begin
				ctrl_en_reg <= i_hwdata[CTRL_EN];
			end
		end
	end

	assign o_issue_ready = ctrl_en_reg & (state_reg == ST_IDLE);
	assign o_wb          = wb_reg;
	assign o_retire      = retire_reg;
	assign o_status      = cur_reg;
	assign o_hreadyout   = 1'b1;
	assign o_hrdata      = hrdata_reg;
	assign o_hresp       = HRESP_OKAY;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	property p_cond_skip;
		issue && !cond_ok |=> !o_wb.valid && o_status == $past(o_status) && state_reg == ST_IDLE;
	endproperty
	a_cond_skip: assert property (p_cond_skip) else $error("failed condition had effect");

	property p_decode;
		dec_read || dec_wfull || dec_wflag |-> i_instr[24:23] == 2'h2 && !i_instr[IR_SETF];
	endproperty
	a_decode: assert property (p_decode) else $error("status op outside test space");

	property p_read;
		go && dec_read |=> o_wb.valid && o_wb.data == $past(rd_val) && o_retire;
	endproperty
	a_read: assert property (p_read) else $error("status read value wrong");

	property p_priv_wr;
		go && dec_wfull && !use_saved && !is_user |=> o_status == $past(i_opnd.rm & SW_DEFINED);
	endproperty
	a_priv_wr: assert property (p_priv_wr) else $error("privileged write lost");

	property p_user_wr;
		go && dec_wfull && !use_saved && is_user
		|=> (cur_reg & ~SW_FLAGS) == $past(cur_reg & ~SW_FLAGS);
	endproperty
	a_user_wr: assert property (p_user_wr) else $error("user changed control bits");

	property p_flag_wr;
		go && dec_wflag && !use_saved |=> (cur_reg & SW_FLAGS) == $past(src_val & SW_FLAGS)
			&& (cur_reg & ~SW_FLAGS) == $past(cur_reg & ~SW_FLAGS);
	endproperty
	a_flag_wr: assert property (p_flag_wr) else $error("flag write wrong");

	property p_saved_wr;
		wr_saved && dec_wfull |=> saved_reg[$past(bank_idx)] == $past(i_opnd.rm & SW_DEFINED);
	endproperty
	a_saved_wr: assert property (p_saved_wr) else $error("saved word write wrong");

	property p_reserved;
		(cur_reg & ~SW_DEFINED) == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bit set");

	property p_single;
		issue && !mul_start |=> o_retire && state_reg == ST_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("status op not single cycle");

	property p_mul_time;
		mul_fin |-> run_reg == 8'(msteps_reg) + 8'(acc_reg);
	endproperty
	a_mul_time: assert property (p_mul_time) else $error("multiply cycle count wrong");

	property p_mul_val;
		mul_fin |=> o_wb.valid && o_wb.idx == $past(dest_reg)
			&& o_wb.data == $past(mcand_reg * mplier_reg + (acc_reg ? rn_reg : '0));
	endproperty
	a_mul_val: assert property (p_mul_val) else $error("multiply result wrong");

	property p_mul_flags;
		mul_fin && setf_reg |=> o_status[BIT_N] == o_wb.data[BIT_N]
			&& o_status[BIT_N-1] == (o_wb.data == '0) && o_status[BIT_V] == $past(cur_reg[BIT_V]);
	endproperty
	a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");
endmodule

// file: tb/stm_core_tb.sv
module stm_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import stm_pkg::*;
	// ---------------------------------------------------------------
	// design under test
	// ---------------------------------------------------------------
	logic        i_clk, i_reset_n, i_issue_valid, i_hsel, i_hwrite;
	logic        o_issue_ready, o_retire, o_hreadyout, o_hresp;
	logic [31:0] i_instr, i_haddr, i_hwdata, o_status, o_hrdata;
	logic [1:0]  i_htrans;
	logic [2:0]  i_hsize;
	stm_opnd_t   i_opnd;
	stm_wb_t     o_wb;
	logic [31:0] sw, sv, rm, rs, rn, p, r, ins;
	int          err_total, comparisons, c, m, n_ops;
	logic [3:0]  rd;
	logic        a, s;
	stm_core stm_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_issue_valid(i_issue_valid), .o_issue_ready(o_issue_ready), .i_instr(i_instr),
		.i_opnd(i_opnd), .o_wb(o_wb), .o_retire(o_retire), .o_status(o_status),
		.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait; a hang counts as a mismatch and ends the run
	task automatic give_up(input int n);
		if (n >= 20) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		@(posedge i_clk);
		{i_hsel, i_htrans, i_hwrite, i_hsize} <= {1'b1, 2'h2, w, HSIZE_WORD};
		i_haddr <= {24'h0, ad};
		for (n = 0; n < 20; n++) begin @(posedge i_clk); if (o_hreadyout === 1'b1) break; end
		give_up(n);
		{i_hsel, i_htrans} <= 3'h0;
		i_hwdata <= wd;
		for (n = 0; n < 20; n++) begin @(posedge i_clk); if (o_hreadyout === 1'b1) break; end
		give_up(n);
		r = o_hrdata;
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input string nm);
		ahb(1'b0, ad, 32'h0);
		chk(nm, e, r);
		chk("hresp", 32'(HRESP_OKAY), 32'(o_hresp));
	endtask
	// issue one instruction and check latency, writeback and the status word
	task automatic op(input logic [31:0] ins, input logic [31:0] om, input logic [31:0] os,
		input logic [31:0] on, input logic wv, input logic [3:0] wi, input logic [31:0] wd,
		input int k);
		int n;
		@(posedge i_clk);
		i_issue_valid <= 1'b1;
		i_instr <= ins;
		i_opnd <= {om, os, on};
		for (n = 0; n < 20; n++) begin @(negedge i_clk); if (o_issue_ready === 1'b1) break; end
		give_up(n);
		@(posedge i_clk);
		i_issue_valid <= 1'b0;
		n_ops++;
		for (n = 0; n < 20; n++) begin @(negedge i_clk); if (o_retire === 1'b1) break; end
		give_up(n);
		chk("latency", 32'(k), 32'(n));
		chk("wb_valid", 32'(wv), 32'(o_wb.valid));
		if (wv) begin
			chk("wb_idx", 32'(wi), 32'(o_wb.idx));
			chk("wb_data", wd, o_wb.data);
		end
		chk("status", sw, o_status);
	endtask
	// multiplier groups: fewest whose upper bits are pure sign
	function automatic int msteps(input logic [31:0] b);
		for (int k = 1; k < 4; k++) begin
			if (($signed(b) >>> (8 * k)) == 0 || ($signed(b) >>> (8 * k)) == -1) return k;
		end
		return 4;
	endfunction
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		r = $urandom(94);
		{i_reset_n, i_issue_valid, i_hsel, i_hwrite, i_htrans, i_hsize} = '0;
		{i_instr, i_haddr, i_hwdata, i_opnd} = '0;
		sw = SW_RESET;
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rdchk(REG_STATUS, 32'h000000d3, "status_reg");
		rdchk(REG_CTRL, 32'h1, "ctrl_reg");
		rdchk(8'h20, 32'h0, "unmapped");
		$display("test registers done");
		op(32'he10f3000, 0, 0, 0, 1, 4'h3, sw, 0);
		sw = 32'hfffff0d2 & SW_DEFINED;
		op(32'he129f000, 32'hfffff0d2, 0, 0, 0, 0, 0, 0);
		sv = 32'h12345617 & SW_DEFINED;
		op(32'he169f000, 32'h12345617, 0, 0, 0, 0, 0, 0);
		op(32'he14f5000, 0, 0, 0, 1, 4'h5, sv, 0);
		rdchk(REG_SAVED, sv, "saved_reg");
		sv = {4'hc, sv[27:0]};
		op(32'he368f4c0, 0, 0, 0, 0, 0, 0, 0);
		op(32'he14f5000, 0, 0, 0, 1, 4'h5, sv, 0);
		sw = {4'h5, sw[27:0]};
		op(32'he128f000, 32'h5abcdef0, 0, 0, 0, 0, 0, 0);
		op(32'h110f3000, 0, 0, 0, 0, 0, 0, 0);
		op(32'h10330291, 7, 32'h12345678, 0, 0, 0, 0, 0);
		$display("test status transfers done");
		for (int i = 0; i < 8; i++) begin
			{a, s, c} = {i[0], 1'($urandom) | (i == 6), i / 2 + 1};
			{rm, rs, rn} = {$urandom, $urandom, $urandom};
			rm = (i == 6) ? 32'h0 : rm;
			rs = (c < 4) ? 32'($signed(rs << (32 - 8 * c)) >>> (32 - 8 * c)) : rs;
			p = rm * rs + (a ? rn : 32'h0);
			rd = 4'(2 + $urandom % 13);
			m = msteps(rs);
			if (s) begin
				sw[31:30] = {p[31], p == 32'h0};
			end
			ins = 32'he0000291 | {a, s, rd, (a ? 4'h4 : 4'h0), 12'h0};
			op(ins, rm, rs, rn, 1, rd, p, m + a);
			rdchk(REG_LASTCY, 32'(m + a + 1), "last_cycles");
		end
		$display("test multiplies done");
		sw = {sw[31:5], MODE_USER};
		op(32'he129f000, sw, 0, 0, 0, 0, 0, 0);
		sw = {4'ha, sw[27:0]};
		op(32'he129f000, 32'ha00000d3, 0, 0, 0, 0, 0, 0);
		rdchk(REG_STATUS, sw, "status_reg");
		rdchk(REG_RETIRE, 32'(n_ops), "retired_reg");
		ahb(1'b1, REG_CTRL, 32'h0);
		@(negedge i_clk);
		chk("ready_off", 32'h0, 32'(o_issue_ready));
		ahb(1'b1, REG_CTRL, 32'h1);
		@(negedge i_clk);
		chk("ready_on", 32'h1, 32'(o_issue_ready));
		$display("test user mode and stall done");
		conclude();
	end
endmodule
